// >>> src/ebs_pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ebs_pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule : ebs_pin_sync
`default_nettype wire

// >>> src/ebs_pkg.sv
// shared types and constants of the external bus cycle phase sequencer
package ebs_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_CS  = 4;
  localparam int unsigned CS_W    = 2;
  localparam int unsigned ADDR_W  = 24;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned CNT_W   = 6;

  // ==========================================================================
  // timing
  localparam int unsigned SYS_CLK_FREQ_KHZ  = 10000;
  localparam int unsigned MIN_PIN_GAP_PS    = 12500;
  localparam int unsigned MAX_PIN_FREQ_KHZ  = 80000;
  // least cycles between pin transitions, rounded up, never below one
  localparam int unsigned MIN_GAP_CYC_RAW =
    (MIN_PIN_GAP_PS * (SYS_CLK_FREQ_KHZ / 1000) + 999999) / 1000000;
  localparam int unsigned MIN_GAP_CYC = (MIN_GAP_CYC_RAW < 1) ? 1 : MIN_GAP_CYC_RAW;
  localparam int unsigned BUS_UNIT_DIV = 1;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] REG_REGION0 = 8'h00;
  localparam logic [7:0] REG_REGION1 = 8'h04;
  localparam logic [7:0] REG_REGION2 = 8'h08;
  localparam logic [7:0] REG_REGION3 = 8'h0C;
  localparam logic [7:0] REG_CTRL    = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;

  // ==========================================================================
  // types
  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_AB   = 6'h02,
    PH_C    = 6'h04,
    PH_D    = 6'h08,
    PH_E    = 6'h10,
    PH_F    = 6'h20
  } ebs_phase_e;

  // region_timing_config layout, 16 bits
  typedef struct packed {
    logic       ready_async;
    logic       ready_pol;
    logic       ready_en;
    logic [1:0] addr_ext_len;
    logic [1:0] hold_len;
    logic [4:0] access_len;
    logic       wdata_setup_len;
    logic [1:0] cmd_delay_len;
    logic       addr_setup_len;
  } ebs_cfg_s;

  localparam logic [15:0] REGION_CFG_RST = 16'h0030;
  localparam logic        CTRL_RST       = 1'b1;

  typedef struct packed {
    ebs_phase_e        phase;
    logic [CNT_W-1:0]  cnt;
  } ebs_step_s;

  typedef struct packed {
    logic [NUM_CS-1:0] cs_n;
    logic              ale;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              data_oe;
  } ebs_pins_s;

  localparam ebs_pins_s PINS_IDLE = '{cs_n: '1, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                                      addr: '0, wdata: '0, data_oe: 1'b0};

endpackage : ebs_pkg

// >>> src/ebs_seq.sv
// external bus cycle phase sequencer top
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Every bus cycle walks the nonzero-length phases of address setup, command delay, data setup, access, hold in order.
// - Each phase length comes from the timing configuration of the selected region.
// - Address setup is one or two units, plus zero to three more on a window change.
// - Command delay is zero to three units and data setup or turnaround zero or one unit.
// - Access is 1 to 32 units and may be stretched by the ready handshake.
// - Hold of address and write data after the command is zero to three units.
// - Pin transitions stay at least 12.5 ns apart, so the clock may not pass 80 MHz.
// - The reference clock pin carries the system clock through the fast driver.
// - At each access sample point inactive ready adds a wait state, active ready ends it.
// - Asynchronous ready passes one more stage and costs at least one wait state.
module ebs_seq #(
  parameter int unsigned UNIT_DIV = ebs_pkg::BUS_UNIT_DIV
) (
  input  wire logic                          mclk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic [7:0]                    reg_addr_i,
  input  wire logic [31:0]                   reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [31:0]                   reg_rdata_o,
  input  wire logic                          req_i,
  input  wire logic                          req_we_i,
  input  wire logic [ebs_pkg::CS_W-1:0]      req_cs_i,
  input  wire logic [ebs_pkg::ADDR_W-1:0]    req_addr_i,
  input  wire logic [ebs_pkg::DATA_W-1:0]    req_wdata_i,
  output logic                               busy_o,
  output logic                               done_o,
  output logic      [ebs_pkg::DATA_W-1:0]    rdata_o,
  input  wire logic                          ready_i,
  input  wire logic [ebs_pkg::DATA_W-1:0]    data_i,
  output ebs_pkg::ebs_pins_s                 pins_o,
  output logic                               ext_clk_pin_out_sel_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    ebs_pkg::ebs_phase_e               phase;
    logic [ebs_pkg::CNT_W-1:0]         cnt;
    logic [ebs_pkg::CS_W-1:0]          cs;
    logic [ebs_pkg::CS_W-1:0]          last_cs;
    logic                              last_vld;
    logic                              we;
    logic                              waited;
    logic                              rdy_late;
    logic [ebs_pkg::NUM_CS-1:0][15:0]  cfg;
    logic                              clk_out_en;
    logic [31:0]                       rdata;
    logic                              done;
    logic                              busy;
    logic [ebs_pkg::DATA_W-1:0]        rd_word;
    ebs_pkg::ebs_pins_s                pins;
  } ebs_state_s;

  ebs_state_s st_ff;
  ebs_state_s nxt_st;

  logic                        tick;
  logic                        rdy_sync;
  logic [ebs_pkg::DATA_W-1:0]  data_sync;

  ebs_unit_div #(.DIV(UNIT_DIV)) u_div (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (tick)
  );

  ebs_pin_sync #(.W(1)) u_rdy_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (ready_i),
    .q_o       (rdy_sync)
  );

  ebs_pin_sync #(.W(ebs_pkg::DATA_W)) u_data_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (data_i),
    .q_o       (data_sync)
  );

  // ==========================================================================
  // phase helpers
  function automatic logic [ebs_pkg::CNT_W-1:0] phase_len(
    input logic [2:0] idx, input ebs_pkg::ebs_cfg_s c, input logic chg);
    logic [ebs_pkg::CNT_W-1:0] len;
    len = '0;
    unique case (idx)
      3'd0: len = 6'({5'h00, c.addr_setup_len}) + 6'h01
                + (chg ? 6'({4'h0, c.addr_ext_len}) : 6'h00);
      3'd1: len = 6'({4'h0, c.cmd_delay_len});
      3'd2: len = 6'({5'h00, c.wdata_setup_len});
      3'd3: len = 6'({1'b0, c.access_len}) + 6'h01;
      3'd4: len = 6'({4'h0, c.hold_len});
      default: len = '0;
    endcase
    return len;
  endfunction : phase_len

  function automatic ebs_pkg::ebs_phase_e idx_phase(input logic [2:0] idx);
    ebs_pkg::ebs_phase_e p;
    p = ebs_pkg::PH_IDLE;
    unique case (idx)
      3'd0: p = ebs_pkg::PH_AB;
      3'd1: p = ebs_pkg::PH_C;
      3'd2: p = ebs_pkg::PH_D;
      3'd3: p = ebs_pkg::PH_E;
      3'd4: p = ebs_pkg::PH_F;
      default: p = ebs_pkg::PH_IDLE;
    endcase
    return p;
  endfunction : idx_phase

  // first phase at or after idx with a nonzero length, idle past the end
  function automatic ebs_pkg::ebs_step_s step_from(
    input logic [2:0] idx, input ebs_pkg::ebs_cfg_s c, input logic chg);
    ebs_pkg::ebs_step_s s;
    logic               found;
    logic [ebs_pkg::CNT_W-1:0] len;
    s.phase = ebs_pkg::PH_IDLE;
    s.cnt   = '0;
    found   = 1'b0;
    for (int k = 0; k < 5; k++) begin
      len = phase_len(3'(k), c, chg);
      if (!found && 3'(k) >= idx && len != '0) begin
        found   = 1'b1;
        s.phase = idx_phase(3'(k));
        s.cnt   = len - 6'h01;
      end
    end
    return s;
  endfunction : step_from

  function automatic logic [2:0] phase_idx(input ebs_pkg::ebs_phase_e p);
    logic [2:0] i;
    i = 3'd5;
    unique case (p)
      ebs_pkg::PH_AB: i = 3'd0;
      ebs_pkg::PH_C:  i = 3'd1;
      ebs_pkg::PH_D:  i = 3'd2;
      ebs_pkg::PH_E:  i = 3'd3;
      ebs_pkg::PH_F:  i = 3'd4;
      ebs_pkg::PH_IDLE: i = 3'd5;
    endcase
    return i;
  endfunction : phase_idx

  ebs_pkg::ebs_cfg_s cur_cfg;
  assign cur_cfg = ebs_pkg::ebs_cfg_s'(st_ff.cfg[st_ff.cs]);

  // ==========================================================================
  // next state
  always_comb begin
    ebs_pkg::ebs_cfg_s  rcfg;
    ebs_pkg::ebs_step_s stp;
    logic               chg;
    logic               rdy_lvl;
    logic               rdy_act;
    rcfg    = ebs_pkg::ebs_cfg_s'(st_ff.cfg[req_cs_i]);
    stp     = '{phase: ebs_pkg::PH_IDLE, cnt: '0};
    chg     = !st_ff.last_vld || (req_cs_i != st_ff.last_cs);
    rdy_lvl = 1'b0;
    rdy_act = 1'b0;
    nxt_st  = st_ff;
    nxt_st.done     = 1'b0;
    nxt_st.rdata    = 32'h0000_0000;
    // async mode adds a third stage behind the synchroniser
    nxt_st.rdy_late = rdy_sync;

    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ebs_pkg::REG_REGION0: nxt_st.cfg[0] = reg_wdata_i[15:0];
        ebs_pkg::REG_REGION1: nxt_st.cfg[1] = reg_wdata_i[15:0];
        ebs_pkg::REG_REGION2: nxt_st.cfg[2] = reg_wdata_i[15:0];
        ebs_pkg::REG_REGION3: nxt_st.cfg[3] = reg_wdata_i[15:0];
        ebs_pkg::REG_CTRL:    nxt_st.clk_out_en = reg_wdata_i[0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ebs_pkg::REG_REGION0: nxt_st.rdata = {16'h0000, st_ff.cfg[0]};
        ebs_pkg::REG_REGION1: nxt_st.rdata = {16'h0000, st_ff.cfg[1]};
        ebs_pkg::REG_REGION2: nxt_st.rdata = {16'h0000, st_ff.cfg[2]};
        ebs_pkg::REG_REGION3: nxt_st.rdata = {16'h0000, st_ff.cfg[3]};
        ebs_pkg::REG_CTRL:    nxt_st.rdata = {31'h0000_0000, st_ff.clk_out_en};
        ebs_pkg::REG_STATUS:  nxt_st.rdata = {22'h00_0000, st_ff.last_vld, st_ff.last_cs,
                                              st_ff.we, st_ff.phase};
        default:              nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    unique case (st_ff.phase)
      ebs_pkg::PH_IDLE: begin
        if (req_i) begin
          stp             = step_from(3'd0, rcfg, chg);
          nxt_st.phase    = stp.phase;
          nxt_st.cnt      = stp.cnt;
          nxt_st.cs       = req_cs_i;
          nxt_st.last_cs  = req_cs_i;
          nxt_st.last_vld = 1'b1;
          nxt_st.we       = req_we_i;
          nxt_st.waited   = 1'b0;
          nxt_st.pins.addr  = req_addr_i;
          nxt_st.pins.wdata = req_wdata_i;
        end
      end
      default: begin
        if (tick) begin
          if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - 6'h01;
          end else if (st_ff.phase == ebs_pkg::PH_E && cur_cfg.ready_en &&
                       cur_cfg.ready_async && !st_ff.waited) begin
            nxt_st.waited = 1'b1;
          end else begin
            rdy_lvl = cur_cfg.ready_async ? st_ff.rdy_late : rdy_sync;
            rdy_act = (rdy_lvl == cur_cfg.ready_pol);
            if (st_ff.phase == ebs_pkg::PH_E && cur_cfg.ready_en && !rdy_act) begin
              nxt_st.waited = 1'b1;
            end else begin
              if (st_ff.phase == ebs_pkg::PH_E) begin
                nxt_st.rd_word = st_ff.we ? st_ff.rd_word : data_sync;
              end
              stp          = step_from(phase_idx(st_ff.phase) + 3'd1, cur_cfg, 1'b0);
              nxt_st.phase = stp.phase;
              nxt_st.cnt   = stp.cnt;
              nxt_st.done  = (stp.phase == ebs_pkg::PH_IDLE);
            end
          end
        end
      end
    endcase

    // pins follow the phase being entered
    nxt_st.pins.cs_n    = '1;
    if (nxt_st.phase != ebs_pkg::PH_IDLE) begin
      nxt_st.pins.cs_n[nxt_st.cs] = 1'b0;
    end
    nxt_st.pins.ale     = (nxt_st.phase == ebs_pkg::PH_AB);
    nxt_st.pins.rd_n    = !(nxt_st.phase == ebs_pkg::PH_E && !nxt_st.we);
    nxt_st.pins.wr_n    = !(nxt_st.phase == ebs_pkg::PH_E && nxt_st.we);
    nxt_st.pins.data_oe = nxt_st.we && (nxt_st.phase == ebs_pkg::PH_D ||
                          nxt_st.phase == ebs_pkg::PH_E || nxt_st.phase == ebs_pkg::PH_F);
    nxt_st.busy         = (nxt_st.phase != ebs_pkg::PH_IDLE);
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff            <= '0;
      st_ff.phase      <= ebs_pkg::PH_IDLE;
      st_ff.cfg        <= {ebs_pkg::NUM_CS{ebs_pkg::REGION_CFG_RST}};
      st_ff.clk_out_en <= ebs_pkg::CTRL_RST;
      st_ff.pins       <= ebs_pkg::PINS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_o = st_ff.rdata;
  assign busy_o      = st_ff.busy;
  assign done_o      = st_ff.done;
  assign rdata_o     = st_ff.rd_word;
  assign pins_o      = st_ff.pins;
  // pad mux routes the system clock to the pin through the fast driver
  assign ext_clk_pin_out_sel_o = st_ff.clk_out_en;

  // ==========================================================================
  // checks
  AST_AB_NEXT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.phase == ebs_pkg::PH_AB |=> st_ff.phase != ebs_pkg::PH_IDLE && st_ff.phase != ebs_pkg::PH_F)
    else $error("address setup left out of order");
  AST_F_NEXT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.phase == ebs_pkg::PH_F |=> st_ff.phase inside {ebs_pkg::PH_F, ebs_pkg::PH_IDLE})
    else $error("hold phase left out of order");
  AST_E_LOAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.phase != ebs_pkg::PH_E && nxt_st.phase == ebs_pkg::PH_E
    |=> st_ff.cnt == 6'({1'b0, cur_cfg.access_len}))
    else $error("access length not taken from region");
  AST_AB_MAX: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.phase == ebs_pkg::PH_AB |-> st_ff.cnt <= 6'h04)
    else $error("address setup above five units");
  AST_C_D_MAX: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (st_ff.phase == ebs_pkg::PH_C |-> st_ff.cnt <= 6'h02) and
    (st_ff.phase == ebs_pkg::PH_D |-> st_ff.cnt == 6'h00))
    else $error("command delay or data setup too long");
  AST_F_MAX: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.phase == ebs_pkg::PH_F |-> st_ff.cnt <= 6'h02)
    else $error("hold phase too long");
  AST_SKIP_C: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.phase == ebs_pkg::PH_AB && nxt_st.phase != ebs_pkg::PH_AB && cur_cfg.cmd_delay_len == 2'b00
    |=> st_ff.phase != ebs_pkg::PH_C)
    else $error("zero command delay not skipped");
  AST_RDY_WAIT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff.phase == ebs_pkg::PH_E && tick && st_ff.cnt == '0 && cur_cfg.ready_en &&
    !cur_cfg.ready_async && (rdy_sync != cur_cfg.ready_pol) |=> st_ff.phase == ebs_pkg::PH_E)
    else $error("inactive ready did not add a wait state");
  AST_ASYNC_WAIT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(st_ff.phase == ebs_pkg::PH_E) && cur_cfg.ready_en && cur_cfg.ready_async
    |-> (st_ff.phase == ebs_pkg::PH_E) [*2])
    else $error("asynchronous ready ended access without a wait state");
  AST_DONE_IDLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    done_o |-> !busy_o && $past(st_ff.phase) != ebs_pkg::PH_IDLE)
    else $error("done without a finished cycle");

endmodule : ebs_seq
`default_nettype wire

// >>> src/ebs_unit_div.sv
// bus time unit divider: one-cycle tick every DIV clocks
`timescale 1ns/100ps
`default_nettype none
module ebs_unit_div #(
  parameter int unsigned DIV = 1
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  // never faster than the pin transition limit allows
  localparam int unsigned EFF = (DIV < ebs_pkg::MIN_GAP_CYC) ? ebs_pkg::MIN_GAP_CYC : DIV;
  localparam logic [7:0]  TOP = 8'(EFF - 1);
  logic [7:0] cnt_ff;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff == TOP);
      cnt_ff <= (cnt_ff == TOP) ? 8'h00 : cnt_ff + 8'h01;
    end
  end
endmodule : ebs_unit_div
`default_nettype wire

// >>> test/ebs_ext_mem_model.sv
// partner model: external memory module on the parallel bus
`timescale 1ns/100ps
`default_nettype none
module ebs_ext_mem_model (
  input  wire logic               mclk_i,
  input  wire logic               rdy_clk_i,
  input  wire ebs_pkg::ebs_pins_s pins_i,
  input  wire logic [7:0]         wait_i,
  input  wire logic               pol_i,
  output logic                    ready_o,
  output logic [15:0]             data_o
);
  logic [15:0] mem [16];
  logic [15:0] last;
  logic [7:0]  wcnt;
  logic        sel;
  logic        cmd;

  initial begin
    last    = 16'h0000;
    wcnt    = 8'h00;
    ready_o = 1'b0;
  end

  // ==========================================================================
  // storage and data lines
  assign sel = (pins_i.cs_n != 4'hF);
  assign cmd = !pins_i.rd_n || !pins_i.wr_n;
  always @(posedge mclk_i) begin
    last <= data_o;
    if (sel && !pins_i.wr_n) begin
      mem[pins_i.addr[3:0]] <= pins_i.wdata;
    end
    wcnt <= cmd ? wcnt + 8'h01 : 8'h00;
  end
  // released lines toggle so a stale word never passes for read data
  assign data_o = (sel && pins_i.wr_n) ? mem[pins_i.addr[3:0]] : ~last;

  // ==========================================================================
  // ready: withheld for wait_i command cycles, dropped when the command ends
  always @(posedge rdy_clk_i) begin
    ready_o <= (cmd && wcnt >= wait_i) ? pol_i : !pol_i;
  end
endmodule : ebs_ext_mem_model
`default_nettype wire

// >>> test/ebs_seq_tb_top.sv
// self-checking testbench of the bus cycle phase sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end
module ebs_seq_tb_top;
  logic               mclk_i, lnk_clk, sys_rst_i;
  logic [7:0]         reg_addr_i;
  logic [31:0]        reg_wdata_i, reg_rdata_o;
  logic               reg_wr_i, reg_rd_i, req_i, req_we_i, busy_o, done_o;
  logic [1:0]         req_cs_i;
  logic [23:0]        req_addr_i;
  logic [15:0]        req_wdata_i, rdata_o, data_i;
  logic               ready_i, sel_o, use_lnk, mdl_pol;
  logic [7:0]         mdl_wait;
  ebs_pkg::ebs_pins_s pins_o;
  int                 n_fail, n_compared, c_ab, c_gap, c_e, c_f;
  logic               seen, oe_cmd;
  logic [23:0]        a_cmd;
  logic [3:0]         cs_cmd;
  logic [15:0]        w_cmd;

  ebs_seq uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_we_i(req_we_i), .req_cs_i(req_cs_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .ready_i(ready_i), .data_i(data_i), .pins_o(pins_o),
    .ext_clk_pin_out_sel_o(sel_o));
  ebs_ext_mem_model mdl (.mclk_i(mclk_i), .rdy_clk_i(use_lnk ? lnk_clk : mclk_i),
    .pins_i(pins_o), .wait_i(mdl_wait), .pol_i(mdl_pol), .ready_o(ready_i), .data_o(data_i));

  // ==========================================================================
  // clocks and phase monitor
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    lnk_clk = 1'b0;
    #13;
    forever #400 lnk_clk = ~lnk_clk;
  end
  always @(posedge mclk_i) begin
    if (pins_o.cs_n != 4'hF) begin
      if (pins_o.ale) c_ab++;
      else if (!pins_o.rd_n || !pins_o.wr_n) begin
        c_e++;
        seen = 1'b1;
        a_cmd = pins_o.addr;
        cs_cmd = pins_o.cs_n;
        w_cmd = pins_o.wdata;
        oe_cmd = pins_o.data_oe;
      end
      else if (!seen) c_gap++;
      else c_f++;
    end
  end

  // ==========================================================================
  // access tasks
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    `CHK("reg_rdata", e, reg_rdata_o)
  endtask : reg_rd

  task automatic bus(input logic we, input logic [1:0] cs, input logic [23:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    {c_ab, c_gap, c_e, c_f} = '0;
    seen = 1'b0;
    @(posedge mclk_i);
    req_i <= 1'b1;
    req_we_i <= we;
    req_cs_i <= cs;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge mclk_i);
    // a changed address while busy must not reach the pins
    req_addr_i <= ~a;
    @(negedge mclk_i);
    `CHK("busy", 1'b1, busy_o)
    repeat (2) @(posedge mclk_i);
    req_i <= 1'b0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (done_o !== 1'b1 && n < 300);
    `CHK("done", 1'b1, done_o)
    `CHK("busy_end", 1'b0, busy_o)
  endtask : bus

  task finish_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end
    else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  function automatic ebs_pkg::ebs_cfg_s mk(input logic s, input logic [1:0] c, input logic d,
      input logic [4:0] a, input logic [1:0] h, input logic [1:0] x, input logic [2:0] r);
    mk = {r, x, h, a, d, c, s};
  endfunction : mk

  // ==========================================================================
  // tests
  initial begin
    #2_000_000;
    n_fail++;
    finish_test;
  end

  initial begin
    ebs_pkg::ebs_cfg_s tcfg [7];
    logic [1:0]        bus_time_unit [7];
    int                lo_t [7];
    int                hi_t [7];
    logic [7:0]        w_t [7];
    logic [15:0]       exp_mem [16];
    logic [23:0]       a;
    logic              we, first;
    logic [1:0]        prev;
    int                ab, lo, hi;
    bus_time_unit  = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    lo_t = '{0, 0, 0, 0, 7, 3, 4};
    hi_t = '{0, 0, 0, 0, 12, 7, 17};
    w_t  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h00};
    {sys_rst_i, reg_wr_i, reg_rd_i, req_i, req_we_i} = 5'b10000;
    {reg_addr_i, reg_wdata_i, req_cs_i, req_addr_i, req_wdata_i} = '0;
    {use_lnk, mdl_pol, mdl_wait, n_fail, n_compared} = '0;
    tcfg[0] = mk(1'b1, 2'h3, 1'b1, 5'h00, 2'h3, 2'h2, 3'h0);
    tcfg[1] = mk(1'b0, 2'h0, 1'b0, 5'h1F, 2'h0, 2'h3, 3'h0);
    tcfg[2] = mk(1'b1, 2'h1, 1'b0, 5'h04, 2'h1, 2'h3, 3'h0);
    tcfg[3] = mk(1'b0, 2'h2, 1'b1, 5'h03, 2'h2, 2'h1, 3'h0);
    tcfg[4] = mk(1'b0, 2'h0, 1'b0, 5'h02, 2'h0, 2'h0, 3'h3);
    tcfg[5] = mk(1'b0, 2'h0, 1'b0, 5'h02, 2'h0, 2'h0, 3'h1);
    tcfg[6] = mk(1'b0, 2'h0, 1'b0, 5'h02, 2'h0, 2'h0, 3'h7);
    first = 1'b1;
    prev = 2'h0;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) reg_rd({4'h0, i[1:0], 2'b00}, {16'h0000, ebs_pkg::REGION_CFG_RST});
    reg_rd(ebs_pkg::REG_CTRL, 32'h0000_0001);
    `CHK("clk_out_sel", 1'b1, sel_o)
    reg_rd(8'h20, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      we = (i == 0 || i == 2);
      a = {20'h00120, 3'b000, (i == 2 || i == 3)};
      reg_wr({4'h0, bus_time_unit[i], 2'b00}, {16'h0000, tcfg[i]});
      reg_rd({4'h0, bus_time_unit[i], 2'b00}, {16'h0000, tcfg[i]});
      mdl_wait = w_t[i];
      mdl_pol = tcfg[i].ready_pol;
      use_lnk = tcfg[i].ready_async;
      ab = int'(tcfg[i].addr_setup_len) + 1;
      if (first || bus_time_unit[i] != prev) ab += int'(tcfg[i].addr_ext_len);
      lo = tcfg[i].ready_en ? lo_t[i] : int'(tcfg[i].access_len) + 1;
      hi = tcfg[i].ready_en ? hi_t[i] : lo;
      bus(we, bus_time_unit[i], a, 16'hC3A0 + 16'(i));
      `CHK("addr_setup", ab, c_ab)
      `CHK("cmd_gap", int'(tcfg[i].cmd_delay_len) + int'(tcfg[i].wdata_setup_len), c_gap)
      `CHK("access_min", 1'b1, c_e >= lo)
      `CHK("access_max", 1'b1, c_e <= hi)
      `CHK("hold", int'(tcfg[i].hold_len), c_f)
      `CHK("addr_pins", a, a_cmd)
      `CHK("cs_pins", ~(4'h1 << bus_time_unit[i]), cs_cmd)
      `CHK("data_oe", we, oe_cmd)
      if (we) begin
        `CHK("wdata_pins", 16'hC3A0 + 16'(i), w_cmd)
        exp_mem[a[3:0]] = 16'hC3A0 + 16'(i);
      end
      else begin
        `CHK("rdata", exp_mem[a[3:0]], rdata_o)
      end
      first = 1'b0;
      prev = bus_time_unit[i];
    end
    // async ready costs at least one wait unit over the programmed access
    `CHK("async_wait", 1'b1, c_e >= int'(tcfg[6].access_len) + 2)
    reg_wr(ebs_pkg::REG_CTRL, 32'h0000_0000);
    reg_rd(ebs_pkg::REG_CTRL, 32'h0000_0000);
    `CHK("clk_out_sel", 1'b0, sel_o)
    // last cycle was a read on region 3, sequencer back to idle
    reg_rd(ebs_pkg::REG_STATUS, 32'h0000_0381);
    finish_test;
  end
endmodule : ebs_seq_tb_top
`default_nettype wire
